// ==== src/dpscd_pkg.sv ====
// Package: constants, opcodes, command word and state types for the pot command decoder
package dpscd_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS    = 5;
    localparam int WIPER_SETTLE_NS  = 5000;
    localparam int WIPER_SETTLE_CYC = (WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W         = 11;
    localparam int NV_WRITE_MS      = 5;
    localparam int NV_WRITE_CYC     = (NV_WRITE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int POWERUP_WAIT_MS  = 1;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int          POTS             = 2;
    localparam int          SETTINGS_PER_POT = 4;
    localparam int          F_OP_LSB         = 4;
    localparam int          F_SEL_LSB        = 2;
    localparam int          F_POT_LSB        = 0;
    localparam int          F_STRAP_LSB      = 0;
    localparam int          STATUS_BUSY_BIT  = 0;
    localparam logic [1:0]  BYTE_ADDR        = 2'h0;
    localparam logic [1:0]  BYTE_INSTR       = 2'h1;
    localparam logic [1:0]  BYTE_DATA        = 2'h2;
    localparam logic [1:0]  BYTE_LAST        = 2'h3;
    localparam logic [2:0]  BIT_LAST         = 3'h7;
    localparam logic [7:0]  WIPER_RESET      = 8'h00;
    localparam logic [7:0]  WIPER_TOP        = 8'hFF;
    localparam logic [7:0]  WIPER_BOTTOM     = 8'h00;

    typedef enum logic [3:0] {
        OP_GLOBAL_S2W   = 4'h1,
        OP_STEP         = 4'h2,
        OP_READ_STATUS  = 4'h5,
        OP_GLOBAL_W2S   = 4'h8,
        OP_READ_WIPER   = 4'h9,
        OP_WRITE_WIPER  = 4'hA,
        OP_READ_SETTING = 4'hB,
        OP_WRITE_SETTING = 4'hC,
        OP_S2W          = 4'hD,
        OP_W2S          = 4'hE
    } dpscd_op_t;

    typedef struct packed {
        logic [3:0] op;
        logic [1:0] sel;
        logic [1:0] pot;
        logic [7:0] data;
    } dpscd_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_USE  = 3'b100
    } dpscd_state_t;

    // ****************************************
    // Opcode classes
    // ****************************************
    function automatic logic dpscd_is_known(input logic [3:0] op);
        return op inside {OP_GLOBAL_S2W, OP_STEP, OP_READ_STATUS, OP_GLOBAL_W2S, OP_READ_WIPER,
                          OP_WRITE_WIPER, OP_READ_SETTING, OP_WRITE_SETTING, OP_S2W, OP_W2S};
    endfunction : dpscd_is_known

    function automatic logic dpscd_is_host_write(input logic [3:0] op);
        return op inside {OP_WRITE_WIPER, OP_WRITE_SETTING};
    endfunction : dpscd_is_host_write

    function automatic logic dpscd_is_read(input logic [3:0] op);
        return op inside {OP_READ_WIPER, OP_READ_SETTING, OP_READ_STATUS};
    endfunction : dpscd_is_read

endpackage : dpscd_pkg

// ==== src/dpscd_mem_if.sv ====
// Interface: port between the command engine and the stored-setting memory
`timescale 1ns/1ps
interface dpscd_mem_if #(parameter int AW = 3, parameter int DW = 8);
    logic [AW-1:0] addr;
    logic          wr_en;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl  (output addr, output wr_en, output wdata, input rdata);
    modport store (input addr, input wr_en, input wdata, output rdata);
endinterface : dpscd_mem_if

// ==== src/dpscd_mem.sv ====
// Stored-setting memory: eight bytes, registered read, keeps contents through reset
`timescale 1ns/1ps
module dpscd_mem #(
    parameter int         AW   = 3,
    parameter int         DW   = 8,
    parameter logic [7:0] FILL = 8'h80
) (
    // Clock
    input wire logic   clk,
    // Access port
    dpscd_mem_if.store mp
);
    logic [DW-1:0] mem [2**AW];

    // Factory contents of the nonvolatile store
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            mem[i] = FILL;
        end
    end

    always_ff @(posedge clk) begin
        if (mp.wr_en) begin
            mem[mp.addr] <= mp.wdata;
        end
        mp.rdata <= mem[mp.addr];
    end
endmodule : dpscd_mem

// ==== src/dpscd_top.sv ====
// Top: serial command front end, command engine and wiper timing of the dual pot
`timescale 1ns/1ps
module dpscd_top
    import dpscd_pkg::*;
#(
    parameter logic [3:0] TYPE_ID         = 4'hA,  // Arbitrary device type code
    parameter int         NV_WRITE_CYCLES = dpscd_pkg::NV_WRITE_CYC
) (
    // System
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    // Serial link
    input  wire logic                 spi_clk,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_si,
    output logic                      spi_so_out,
    output logic                      spi_so_oe_n,
    // Strap pins
    input  wire logic [1:0]           strap_address_bits,
    // Wiper and status
    output logic [dpscd_pkg::POTS-1:0][7:0] wiper_level,
    output logic                      write_pending_flag
);
    import dpscd_pkg::*;

    localparam int BUSY_W = $clog2(NV_WRITE_CYCLES + 1);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_s1_r;
    logic rst_n_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ****************************************
    // Link: strap synchroniser
    // ****************************************
    logic [1:0] strap_s1_r;
    logic [1:0] strap_s2_r;

    always_ff @(posedge spi_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
        end else begin
            strap_s1_r <= strap_address_bits;
            strap_s2_r <= strap_s1_r;
        end
    end

    // ****************************************
    // Link: receive on rising edge
    // ****************************************
    logic [2:0]  bit_cnt_r;
    logic [1:0]  byte_idx_r;
    logic [6:0]  sh_r;
    logic        addr_ok_r;
    logic [7:0]  instr_r;
    logic        step_r;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic [3:0]  rx_op;
    logic [3:0]  instr_op;

    assign rx_byte   = {sh_r, spi_si};
    assign byte_done = (bit_cnt_r == BIT_LAST);
    assign rx_op     = rx_byte[F_OP_LSB +: 4];
    assign instr_op  = instr_r[F_OP_LSB +: 4];

    // Chip select high clears the frame state
    always_ff @(posedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_r  <= 3'h0;
            byte_idx_r <= BYTE_ADDR;
            sh_r       <= 7'h00;
            addr_ok_r  <= 1'b0;
            instr_r    <= 8'h00;
            step_r     <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            sh_r      <= rx_byte[6:0];
            if (byte_done) begin
                if (byte_idx_r != BYTE_LAST) begin
                    byte_idx_r <= byte_idx_r + 2'h1;
                end
                if (byte_idx_r == BYTE_ADDR) begin
                    addr_ok_r <= (rx_byte[F_OP_LSB +: 4] == TYPE_ID)
                              && (rx_byte[F_STRAP_LSB +: 2] == strap_s2_r);
                end
                if (byte_idx_r == BYTE_INSTR) begin
                    instr_r <= rx_byte;
                    if (addr_ok_r && rx_op == OP_STEP) begin
                        step_r <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // Link: command event to engine
    // ****************************************
    logic       ev_fire;
    dpscd_cmd_t ev_word;
    logic       ev_tgl_r;
    dpscd_cmd_t ev_word_r;

    always_comb begin
        ev_fire = 1'b0;
        ev_word = '0;
        if (addr_ok_r) begin
            if (step_r) begin
                ev_fire = 1'b1;
                ev_word = {instr_r, 7'h00, spi_si};
            end else if (byte_done && byte_idx_r == BYTE_INSTR) begin
                // Step command only arms stepping, later clocks move the wiper
                ev_fire = dpscd_is_known(rx_op) && !dpscd_is_host_write(rx_op) && rx_op != OP_STEP;
                ev_word = {rx_byte, 8'h00};
            end else if (byte_done && byte_idx_r == BYTE_DATA) begin
                ev_fire = dpscd_is_host_write(instr_op);
                ev_word = {instr_r, rx_byte};
            end
        end
    end

    // Toggle survives frame end so no event is lost or faked
    always_ff @(posedge spi_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ev_tgl_r  <= 1'b0;
            ev_word_r <= '0;
        end else if (ev_fire) begin
            ev_tgl_r  <= ~ev_tgl_r;
            ev_word_r <= ev_word;
        end
    end

    // ****************************************
    // Link: transmit on falling edge
    // ****************************************
    logic [7:0] rd_data_r;
    logic [6:0] out_sh_r;
    logic       out_loaded_r;
    logic       rd_start;

    assign rd_start = addr_ok_r && dpscd_is_read(instr_op) && byte_idx_r == BYTE_DATA
                   && bit_cnt_r == 3'h0 && !out_loaded_r;

    // Falling-edge shift serves both idle-low and idle-high clock modes
    always_ff @(negedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_so_out   <= 1'b1;
            spi_so_oe_n  <= 1'b1;
            out_sh_r     <= 7'h00;
            out_loaded_r <= 1'b0;
        end else if (rd_start) begin
            spi_so_out   <= rd_data_r[7];
            out_sh_r     <= rd_data_r[6:0];
            spi_so_oe_n  <= 1'b0;
            out_loaded_r <= 1'b1;
        end else if (out_loaded_r) begin
            spi_so_out <= out_sh_r[6];
            out_sh_r   <= {out_sh_r[5:0], 1'b0};
        end
    end

    // ****************************************
    // Engine: crossings from the link
    // ****************************************
    logic ev_s1_r;
    logic ev_s2_r;
    logic ev_s3_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic ev_new;
    logic cs_rise;

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ev_s1_r <= 1'b0;
            ev_s2_r <= 1'b0;
            ev_s3_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            ev_s1_r <= ev_tgl_r;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
            cs_s1_r <= spi_cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    assign ev_new  = ev_s2_r ^ ev_s3_r;
    assign cs_rise = cs_s2_r & ~cs_s3_r;

    // ****************************************
    // Engine: command sequencer
    // ****************************************
    dpscd_mem_if #(.AW(3), .DW(8)) mem_bus ();

    dpscd_state_t                 state_r;
    dpscd_cmd_t                   cmd_r;
    logic                         pot_r;
    logic [POTS-1:0][7:0]         wiper_r;
    logic                         busy_r;
    logic                         wp_we;
    logic [7:0]                   wp_val;
    logic                         is_global;

    assign is_global = (cmd_r.op == OP_GLOBAL_S2W) || (cmd_r.op == OP_GLOBAL_W2S);

    always_comb begin
        mem_bus.addr  = {pot_r, cmd_r.sel};
        mem_bus.wr_en = (state_r == ST_EXEC) && !busy_r
                     && (cmd_r.op inside {OP_WRITE_SETTING, OP_W2S, OP_GLOBAL_W2S});
        mem_bus.wdata = (cmd_r.op == OP_WRITE_SETTING) ? cmd_r.data : wiper_r[pot_r];
    end

    // Power-up acts as a global restore from setting zero
    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r   <= ST_EXEC;
            cmd_r     <= {OP_GLOBAL_S2W, 2'h0, 2'h0, 8'h00};
            pot_r     <= 1'b0;
            rd_data_r <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (ev_new) begin
                        cmd_r   <= ev_s2_r ? ev_word_r : ev_word_r;
                        pot_r   <= ev_word_r.pot[0] & ~(ev_word_r.op inside {OP_GLOBAL_S2W, OP_GLOBAL_W2S});
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_r <= ST_IDLE;
                    case (cmd_r.op)
                        OP_READ_WIPER:  rd_data_r <= wiper_r[pot_r];
                        OP_READ_STATUS: rd_data_r <= 8'(busy_r) << STATUS_BUSY_BIT;
                        OP_GLOBAL_W2S: begin
                            if (!pot_r) begin
                                pot_r   <= 1'b1;
                                state_r <= ST_EXEC;
                            end
                        end
                        OP_READ_SETTING, OP_S2W, OP_GLOBAL_S2W: state_r <= ST_USE;
                        default: ;
                    endcase
                end
                ST_USE: begin
                    state_r <= ST_IDLE;
                    if (cmd_r.op == OP_READ_SETTING) begin
                        rd_data_r <= mem_bus.rdata;
                    end else if (is_global && !pot_r) begin
                        pot_r   <= 1'b1;
                        state_r <= ST_EXEC;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    dpscd_mem #(.AW(3), .DW(8)) u_mem (
        .clk (mclk),
        .mp  (mem_bus)
    );

    // ****************************************
    // Engine: wiper position registers
    // ****************************************
    always_comb begin
        wp_we  = 1'b0;
        wp_val = wiper_r[pot_r];
        if (state_r == ST_EXEC && cmd_r.op == OP_WRITE_WIPER) begin
            wp_we  = 1'b1;
            wp_val = cmd_r.data;
        end else if (state_r == ST_EXEC && cmd_r.op == OP_STEP) begin
            wp_we = 1'b1;
            if (cmd_r.data[0] && wiper_r[pot_r] != WIPER_TOP) begin
                wp_val = wiper_r[pot_r] + 8'h01;
            end else if (!cmd_r.data[0] && wiper_r[pot_r] != WIPER_BOTTOM) begin
                wp_val = wiper_r[pot_r] - 8'h01;
            end
        end else if (state_r == ST_USE && cmd_r.op != OP_READ_SETTING) begin
            wp_we  = 1'b1;
            wp_val = mem_bus.rdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wiper_r <= {POTS{WIPER_RESET}};
        end else if (wp_we) begin
            wiper_r[pot_r] <= wp_val;
        end
    end

    // ****************************************
    // Engine: wiper output settle delay
    // ****************************************
    logic [SETTLE_W-1:0] settle_cnt_r;

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            settle_cnt_r <= '0;
            wiper_level  <= {POTS{WIPER_RESET}};
        end else if (wp_we) begin
            settle_cnt_r <= SETTLE_W'(WIPER_SETTLE_CYC);
        end else if (settle_cnt_r != '0) begin
            settle_cnt_r <= settle_cnt_r - 1'b1;
            if (settle_cnt_r == SETTLE_W'(1)) begin
                wiper_level <= wiper_r;
            end
        end
    end

    // ****************************************
    // Engine: nonvolatile commit
    // ****************************************
    logic              commit_pend_r;
    logic [BUSY_W-1:0] busy_cnt_r;

    assign write_pending_flag = busy_r;

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            commit_pend_r <= 1'b0;
            busy_r        <= 1'b0;
            busy_cnt_r    <= '0;
        end else begin
            if (cs_rise && commit_pend_r) begin
                commit_pend_r <= mem_bus.wr_en;
                busy_r        <= 1'b1;
                busy_cnt_r    <= BUSY_W'(NV_WRITE_CYCLES);
            end else begin
                if (mem_bus.wr_en) begin
                    commit_pend_r <= 1'b1;
                end
                if (busy_cnt_r != '0) begin
                    busy_cnt_r <= busy_cnt_r - 1'b1;
                    if (busy_cnt_r == BUSY_W'(1)) begin
                        busy_r <= 1'b0;
                    end
                end
            end
        end
    end
endmodule : dpscd_top

// ==== bench/dpscd_top_asserts.sv ====
// Port-level checks for the pot command decoder
`timescale 1ns/1ps
module dpscd_top_asserts
    import dpscd_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = dpscd_pkg::NV_WRITE_CYC
) (
    // System
    input wire logic                            mclk,
    input wire logic                            nrst,
    // Serial link
    input wire logic                            spi_clk,
    input wire logic                            spi_cs_n,
    input wire logic                            spi_so_out,
    input wire logic                            spi_so_oe_n,
    // Wiper and status
    input wire logic [dpscd_pkg::POTS-1:0][7:0] wiper_level,
    input wire logic                            write_pending_flag
);
    logic [31:0] busy_cnt_r;
    logic [15:0] quiet_cnt_r;
    logic [11:0] pu_cnt_r;
    logic        pu_wait_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Length of the current busy period
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= write_pending_flag ? busy_cnt_r + 32'h1 : 32'h0;
        end
    end

    // Cycles since the wiper outputs last moved
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            quiet_cnt_r <= 16'h0;
        end else if ($stable(wiper_level)) begin
            quiet_cnt_r <= (quiet_cnt_r == 16'hFFFF) ? quiet_cnt_r : quiet_cnt_r + 16'h1;
        end else begin
            quiet_cnt_r <= 16'h0;
        end
    end

    // Cycles from reset release to the first wiper restore
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pu_cnt_r  <= 12'h000;
            pu_wait_r <= 1'b1;
        end else if (pu_wait_r) begin
            pu_cnt_r  <= pu_cnt_r + 12'h001;
            pu_wait_r <= $stable(wiper_level);
        end
    end

    sequence wiper_moves;
        !$stable(wiper_level);
    endsequence

    sequence frame_idle;
        spi_cs_n && $past(spi_cs_n);
    endsequence

    chk_oe_idle: assert property (frame_idle |-> spi_so_oe_n && spi_so_out)
        else $error("serial output driven outside a frame");
    chk_so_frame: assert property (!spi_so_oe_n |-> !spi_cs_n)
        else $error("serial output driven while deselected");
    chk_so_shift: assert property (!$stable(spi_so_out) && !spi_so_oe_n && !$past(spi_so_oe_n) |-> !spi_clk)
        else $error("serial output moved away from a falling clock");
    chk_oe_start: assert property ($fell(spi_so_oe_n) |-> !spi_clk && !spi_cs_n)
        else $error("read data started at a wrong moment");
    chk_busy_start: assert property ($rose(write_pending_flag) |-> frame_idle)
        else $error("write cycle started inside a frame");
    chk_busy_len: assert property ($fell(write_pending_flag) |->
        busy_cnt_r >= 32'(NV_WRITE_CYCLES - 1) && busy_cnt_r <= 32'(NV_WRITE_CYCLES + 1))
        else $error("write cycle length wrong");
    chk_wiper_quiet: assert property (wiper_moves |-> quiet_cnt_r >= 16'd995)
        else $error("wiper moved before settle time");
    chk_power_restore: assert property (pu_wait_r ##0 wiper_moves |-> pu_cnt_r >= 12'd1000)
        else $error("wiper restored too early after power-up");
    chk_power_late: assert property (pu_wait_r |-> pu_cnt_r <= 12'd2000)
        else $error("wiper not restored after power-up");
endmodule : dpscd_top_asserts

bind dpscd_top dpscd_top_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) dpscd_top_asserts_inst (
    .mclk(mclk), .nrst(nrst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_so_out(spi_so_out),
    .spi_so_oe_n(spi_so_oe_n), .wiper_level(wiper_level), .write_pending_flag(write_pending_flag)
);

// ==== bench/dpscd_host_model.sv ====
// Host serial master model issuing command frames
`timescale 1ns/1ps
module dpscd_host_model (
    // Serial link
    output logic     spi_clk,
    output logic     spi_cs_n,
    output logic     spi_si,
    input wire logic spi_so_out,
    input wire logic spi_so_oe_n
);
    realtime    t_rise;
    logic [7:0] rd_byte;
    logic       rd_drove;
    event       rd_ev;

    initial begin
        spi_clk  = 1'b0;
        spi_cs_n = 1'b1;
        spi_si   = 1'b0;
        t_rise   = 0.0;
    end

    // Clock idles at cpol and stands still between frames
    task automatic frame(input logic [23:0] bits, input int nb, input logic cpol, input int half, input logic rd);
        logic [7:0] acc;
        logic       drv;
        acc = 8'h00;
        drv = 1'b1;
        spi_clk <= cpol;
        #(half);
        spi_cs_n <= 1'b0;
        #(half);
        for (int i = 0; i < nb; i++) begin
            spi_clk <= 1'b0;
            spi_si  <= bits[23-i];
            #(half);
            spi_clk <= 1'b1;
            t_rise = $realtime;
            if (i >= 16) begin
                acc = {acc[6:0], spi_so_out};
                drv = drv & ~spi_so_oe_n;
            end
            #(half);
        end
        spi_clk <= cpol;
        #(half);
        spi_cs_n <= 1'b1;
        spi_si   <= ~spi_si;
        rd_byte  = acc;
        rd_drove = drv;
        if (rd) begin
            -> rd_ev;
        end
        #(4 * half);
    endtask : frame
endmodule : dpscd_host_model

// ==== bench/testbench.sv ====
// Self-checking bench for the dual pot command decoder
`timescale 1ns/1ps
module testbench;
    import dpscd_pkg::*;
    localparam int         NVC = 2000;
    localparam logic [3:0] TID = 4'hA;  // Arbitrary device type code

    typedef struct {
        logic [15:0] val;
        realtime     t0;
    } dpscd_note_t;

    logic                 mclk = 1'b0;
    logic                 nrst = 1'b0;
    logic [1:0]           strap_address_bits = 2'h0;
    logic                 spi_clk, spi_cs_n, spi_si, spi_so_out, spi_so_oe_n, write_pending_flag;
    logic [POTS-1:0][7:0] wiper_level;
    logic [POTS-1:0][7:0] wiper_q = '0;
    logic [7:0]           wexp[2];
    logic [7:0]           v;
    logic                 p;
    dpscd_note_t          cur, exp_q[$];
    int                   miscompares = 0;
    int                   n_tests = 0;
    int                   seed = 32'h501500EE;

    always #2.5 mclk = ~mclk;

    dpscd_top #(.TYPE_ID(TID), .NV_WRITE_CYCLES(NVC)) dpscd_top_inst (.mclk, .nrst, .spi_clk, .spi_cs_n,
        .spi_si, .spi_so_out, .spi_so_oe_n, .strap_address_bits, .wiper_level, .write_pending_flag);
    dpscd_host_model dpscd_host_model_inst (.spi_clk, .spi_cs_n, .spi_si, .spi_so_out, .spi_so_oe_n);

    task automatic end_sim;
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask : check

    function automatic dpscd_note_t take();
        dpscd_note_t n = '{16'h0, 0.0};
        if (exp_q.size() > 0) n = exp_q.pop_front();
        return n;
    endfunction : take

    task automatic note(input logic [15:0] val, input realtime t0);
        exp_q.push_back('{val, t0});
    endtask : note

    // Random serial mode per frame, off the system clock phase
    task automatic cmd(input logic [3:0] ty, input logic [1:0] sa, input logic [15:0] body, input int nb,
                       input logic rd, input int half = 40);
        #1.3;
        dpscd_host_model_inst.frame({ty, 2'h0, sa, body}, nb, 1'($random(seed)), half, rd);
        repeat (40) @(posedge mclk);
    endtask : cmd

    task automatic hold_until(input logic lvl);
        for (int i = 0; i < 3000 && (exp_q.size() > 0 || write_pending_flag !== lvl); i++) begin
            @(posedge mclk);
        end
        if (exp_q.size() > 0 || write_pending_flag !== lvl) begin
            miscompares++;
            end_sim();
        end
    endtask : hold_until

    always @(posedge mclk) begin
        if (nrst && wiper_level !== wiper_q) begin
            cur = take();
            check("wiper", cur.val, wiper_level);
            check("wiper delay", 16'h1, 16'($realtime - cur.t0 >= 5000.0 && $realtime - cur.t0 <= 10000.0));
        end
        wiper_q <= wiper_level;
    end

    always @(dpscd_host_model_inst.rd_ev) begin
        cur = take();
        check("read", cur.val, {7'h0, dpscd_host_model_inst.rd_drove, dpscd_host_model_inst.rd_byte});
    end

    initial begin
        repeat (5) @(posedge mclk);
        nrst               <= 1'b1;
        strap_address_bits <= 2'($random(seed));
        note(16'h8080, $realtime);
        hold_until(1'b0);
        // Foreign type or strap stays silent
        note(16'h00FF, 0.0);
        cmd(4'h3, strap_address_bits, 16'h9100, 24, 1);
        note(16'h00FF, 0.0);
        cmd(TID, ~strap_address_bits, 16'h9100, 24, 1);
        cmd(TID, ~strap_address_bits, 16'hA011, 24, 0);
        cmd(TID, strap_address_bits, 16'hA155, 24, 0);
        note(16'h5580, dpscd_host_model_inst.t_rise);
        hold_until(1'b0);
        note(16'h0155, 0.0);
        cmd(TID, strap_address_bits, 16'h9100, 24, 1);
        // Setting write, busy flag and status
        cmd(TID, strap_address_bits, 16'hC43C, 24, 0);
        hold_until(1'b1);
        note(16'h0101, 0.0);
        cmd(TID, strap_address_bits, 16'h5100, 24, 1);
        hold_until(1'b0);
        note(16'h0100, 0.0);
        cmd(TID, strap_address_bits, 16'h5100, 24, 1);
        note(16'h013C, 0.0);
        cmd(TID, strap_address_bits, 16'hB400, 24, 1);
        // Transfers between wipers and settings
        cmd(TID, strap_address_bits, 16'hD400, 16, 0);
        note(16'h553C, dpscd_host_model_inst.t_rise);
        hold_until(1'b0);
        cmd(TID, strap_address_bits, 16'hE900, 16, 0);
        hold_until(1'b1);
        hold_until(1'b0);
        cmd(TID, strap_address_bits, 16'h8C00, 16, 0);
        hold_until(1'b1);
        hold_until(1'b0);
        note(16'h0155, 0.0);
        cmd(TID, strap_address_bits, 16'hB900, 24, 1);
        note(16'h013C, 0.0);
        cmd(TID, strap_address_bits, 16'hBC00, 24, 1);
        cmd(TID, strap_address_bits, 16'h1000, 16, 0);
        note(16'h8080, dpscd_host_model_inst.t_rise);
        hold_until(1'b0);
        // Step mode on a slow clock: seven up, one down
        cmd(TID, strap_address_bits, 16'h20EF, 24, 0, 200);
        note(16'h8086, dpscd_host_model_inst.t_rise);
        hold_until(1'b0);
        wexp = '{8'h86, 8'h80};
        for (int i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            p = 1'($random(seed));
            if (v == wexp[p]) v = ~v;
            wexp[p] = v;
            cmd(TID, strap_address_bits, {7'h50, p, v}, 24, 0);
            note({wexp[1], wexp[0]}, dpscd_host_model_inst.t_rise);
            hold_until(1'b0);
        end
        end_sim();
    end
endmodule : testbench
